// >>> verilog/cff_pkg.sv
package cff_pkg;

  // ----------------------------------------------------------------------
  // Register offsets of the flag bank
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_TIMER_FLAGS = 8'h24;
  localparam logic [7:0] OFS_TEMP_FLAGS  = 8'h25;
  localparam logic [7:0] OFS_FAULT_A     = 8'h26;
  localparam logic [7:0] OFS_FAULT_B     = 8'h27;

  // Reset value shared by every flag register.
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Condition vector layout (index of each supervisory condition)
  // ----------------------------------------------------------------------
  localparam int NUM_COND       = 19;
  localparam int IDX_TOPUP      = 18;
  localparam int IDX_LOWBAT     = 17;
  localparam int IDX_COLD       = 16;
  localparam int IDX_COOL       = 15;
  localparam int IDX_WARM       = 14;
  localparam int IDX_HOT        = 13;
  localparam int IDX_IBATREG    = 12;
  localparam int IDX_BUSOVP     = 11;
  localparam int IDX_BATOVP     = 10;
  localparam int IDX_BUSOCP     = 9;
  localparam int IDX_BATOCP     = 8;
  localparam int IDX_CONVOCP    = 7;
  localparam int IDX_IN2OVP     = 6;
  localparam int IDX_IN1OVP     = 5;
  localparam int IDX_SYSSHORT   = 4;
  localparam int IDX_SYSOVP     = 3;
  localparam int IDX_BOOSTOVP   = 2;
  localparam int IDX_BOOSTUVP   = 1;
  localparam int IDX_TSHUT      = 0;

  // Conditions that flag on any change rather than on a rising edge.
  localparam logic [18:0] CHANGE_MODE = 19'h1F000;

  // Reset value of synchroniser and settled-level flops.
  localparam logic [18:0] COND_RESET = 19'h00000;

  // Supervisory condition levels from the analog side, MSB first.
  typedef struct packed {
    logic topupTimerExpired;
    logic batteryTooLowForBoost;
    logic thermistorBelowCold;
    logic thermistorBelowCool;
    logic thermistorAboveWarm;
    logic thermistorAboveHot;
    logic batteryCurrentReg;
    logic inputBusOvervolt;
    logic batteryOvervolt;
    logic inputBusOvercurrent;
    logic batteryDischargeOvercurrent;
    logic converterOvercurrent;
    logic secondInputOvervolt;
    logic firstInputOvervolt;
    logic systemShort;
    logic systemOvervolt;
    logic boostOutputOvervolt;
    logic boostOutputUndervolt;
    logic dieThermalShutdown;
  } cff_cond_t;

endpackage

// >>> verilog/cff_flag_bank.sv
`timescale 1ns/1ps

module cff_flag_bank
  import cff_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk,
  input  wire logic              arst_n,
  // Condition levels from the analog supervisors.
  input  wire cff_pkg::cff_cond_t condIn,
  // Read port from the serial register engine.
  input  wire logic              rdStrobe,
  input  wire logic [7:0]        rdAddr,
  output logic      [7:0]        rdData,
  output logic                   rdValid
);

  // ----------------------------------------------------------------------
  // Condition synchronisers and event detection
  // ----------------------------------------------------------------------
  logic [NUM_COND-1:0] condRaw;
  logic [NUM_COND-1:0] sync1;
  logic [NUM_COND-1:0] sync2;
  logic [NUM_COND-1:0] sync3;
  logic [NUM_COND-1:0] settled;
  logic [NUM_COND-1:0] flags;
  logic [NUM_COND-1:0] next_flags;
  logic [NUM_COND-1:0] event_;
  logic [NUM_COND-1:0] clearMask;
  logic [NUM_COND-1:0] agree;
  logic [NUM_COND-1:0] next_settled;

  assign condRaw = condIn;

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1 <= COND_RESET;
      sync2 <= COND_RESET;
      sync3 <= COND_RESET;
    end
    else
    begin
      sync1 <= condRaw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level is accepted once stages two and three agree.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      settled <= COND_RESET;
    else
      settled <= next_settled;
  end

  assign agree        = ~(sync2 ^ sync3);
  assign next_settled = (agree & sync3) | (~agree & settled);

  // ----------------------------------------------------------------------
  // Read decode: a read clears the flags of the register it returns
  // ----------------------------------------------------------------------
  wire hitTimer = rdStrobe && (rdAddr == OFS_TIMER_FLAGS);
  wire hitTemp  = rdStrobe && (rdAddr == OFS_TEMP_FLAGS);
  wire hitFaultA = rdStrobe && (rdAddr == OFS_FAULT_A);
  wire hitFaultB = rdStrobe && (rdAddr == OFS_FAULT_B);

  assign clearMask = {hitTimer, {5{hitTemp}}, {8{hitFaultA}},
                      {5{hitFaultB}}};

  // Per-condition event: rising edge, or any change for zone crossings and current regulation.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COND; gi++)
    begin : g_evt
      if (CHANGE_MODE[gi])
      begin : g_change
        // Thermistor zones and current regulation flag both ways.
        assign event_[gi] = agree[gi]
          && (sync3[gi] != settled[gi]);
      end
      else
      begin : g_rise
        // Protection entries and timer expiry flag on entry only.
        assign event_[gi] = agree[gi]
          && sync3[gi]
          && !settled[gi];
      end
    end
  endgenerate

  // A new event wins over a clear arriving in the same cycle.
  assign next_flags = (flags & ~clearMask) | event_;

  // Sticky flag storage, zero after power-on reset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      flags <= {NUM_COND{1'b0}};
    else
      flags <= next_flags;
  end

  // ----------------------------------------------------------------------
  // Register images and read data
  // ----------------------------------------------------------------------
  logic [7:0] imgTimer;
  logic [7:0] imgTemp;
  logic [7:0] imgFaultA;
  logic [7:0] imgFaultB;
  logic [7:0] next_rdData;

  assign imgTimer  = {7'h00, flags[IDX_TOPUP]};
  assign imgTemp   = {3'h0, flags[IDX_LOWBAT:IDX_HOT]};
  assign imgFaultA = flags[IDX_IBATREG:IDX_IN1OVP];
  assign imgFaultB = {flags[IDX_SYSSHORT:IDX_BOOSTUVP], 1'b0,
                      flags[IDX_TSHUT], 2'h0};

  // Unmapped offsets read as zero; writes do not exist on this bank.
  assign next_rdData = hitTimer  ? imgTimer  :
                       hitTemp   ? imgTemp   :
                       hitFaultA ? imgFaultA :
                       hitFaultB ? imgFaultB : FLAG_RESET;

  // Read answer one cycle after the strobe.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdData  <= FLAG_RESET;
      rdValid <= 1'b0;
    end
    else
    begin
      rdData  <= next_rdData;
      rdValid <= rdStrobe;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [7:0] addrQ;

  // Address of the read being answered, for checking only.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      addrQ <= 8'h00;
    else
      addrQ <= rdAddr;
  end

  chk_topup_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_TOPUP] && sync3[IDX_TOPUP] && !settled[IDX_TOPUP])
    |=> flags[IDX_TOPUP])
    else $error("Top-up expiry edge did not set its flag.");

  chk_temp_reserved: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rdValid && addrQ == OFS_TEMP_FLAGS) |-> (rdData[7:5] == 3'h0))
    else $error("Reserved bits of temperature flags not zero.");

  chk_lowbat_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_LOWBAT] && sync3[IDX_LOWBAT] && !settled[IDX_LOWBAT])
    ##1 (rdStrobe && rdAddr == OFS_TEMP_FLAGS)
    |=> rdData[4])
    else $error("Low battery flag not returned after its edge.");

  chk_cold_fall: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!sync2[IDX_COLD] && !sync3[IDX_COLD] && settled[IDX_COLD])
    |=> flags[IDX_COLD])
    else $error("Leaving the cold zone did not set its flag.");

  chk_hot_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_HOT]) |-> flags[IDX_HOT])
    else $error("Entering the hot zone did not set its flag.");

  chk_faulta_data: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rdStrobe && rdAddr == OFS_FAULT_A)
    |=> (rdValid && rdData == $past(flags[IDX_IBATREG:IDX_IN1OVP])))
    else $error("Fault register A read data mismatch.");

  chk_ibatreg_exit: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(settled[IDX_IBATREG]) |-> flags[IDX_IBATREG])
    else $error("Leaving current regulation did not set its flag.");

  chk_ovp_norelease: assert property (
    @(posedge clk) disable iff (!arst_n)
    ($fell(settled[IDX_BUSOVP]) && !$past(flags[IDX_BUSOVP])
     && !$past(clearMask[IDX_BUSOVP])) |-> !flags[IDX_BUSOVP])
    else $error("Leaving bus over-voltage wrongly set its flag.");

  chk_faultb_reserved: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rdValid && addrQ == OFS_FAULT_B)
    |-> (rdData[3] == 1'b0 && rdData[1:0] == 2'h0))
    else $error("Reserved bits of fault register B not zero.");

  chk_tshut_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_TSHUT] && sync3[IDX_TSHUT] && !settled[IDX_TSHUT])
    |=> flags[IDX_TSHUT]
    ##1 (flags[IDX_TSHUT] || $past(clearMask[IDX_TSHUT])))
    else $error("Thermal shutdown flag not held after its edge.");

  chk_flag_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (flags[IDX_SYSSHORT] && !clearMask[IDX_SYSSHORT])
    |=> flags[IDX_SYSSHORT])
    else $error("System short flag dropped without a read.");

  chk_read_clears: assert property (
    @(posedge clk) disable iff (!arst_n)
    (rdStrobe && rdAddr == OFS_FAULT_B && !event_[IDX_SYSOVP])
    |=> !flags[IDX_SYSOVP])
    else $error("Read of fault register B did not clear its flag.");

  chk_cool_change: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_COOL] == sync3[IDX_COOL]
     && sync3[IDX_COOL] != settled[IDX_COOL]) |=> flags[IDX_COOL])
    else $error("Crossing the cool threshold did not set its flag.");

  chk_warm_fall: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(settled[IDX_WARM]) |-> flags[IDX_WARM])
    else $error("Leaving the warm zone did not set its flag.");

  chk_busovp_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_BUSOVP] && sync3[IDX_BUSOVP] && !settled[IDX_BUSOVP])
    |=> flags[IDX_BUSOVP])
    else $error("Bus over-voltage entry did not set its flag.");

  chk_batovp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_BATOVP]) |-> flags[IDX_BATOVP])
    else $error("Battery over-voltage entry did not set its flag.");

  chk_busocp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_BUSOCP]) |-> flags[IDX_BUSOCP])
    else $error("Bus over-current entry did not set its flag.");

  chk_batocp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_BATOCP]) |-> flags[IDX_BATOCP])
    else $error("Discharge over-current entry did not set its flag.");

  chk_convocp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_CONVOCP]) |-> flags[IDX_CONVOCP])
    else $error("Converter over-current entry did not set its flag.");

  chk_in2ovp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_IN2OVP]) |-> flags[IDX_IN2OVP])
    else $error("Second input over-voltage did not set its flag.");

  chk_in1ovp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_IN1OVP]) |-> flags[IDX_IN1OVP])
    else $error("First input over-voltage did not set its flag.");

  chk_sysshort_latch: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_SYSSHORT] && sync3[IDX_SYSSHORT] && !settled[IDX_SYSSHORT])
    |=> flags[IDX_SYSSHORT])
    else $error("System short halt did not set its flag.");

  chk_sysovp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_SYSOVP]) |-> flags[IDX_SYSOVP])
    else $error("System over-voltage halt did not set its flag.");

  chk_boostovp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_BOOSTOVP]) |-> flags[IDX_BOOSTOVP])
    else $error("Boost stop on bus over-voltage did not set its flag.");

  chk_boostuvp_rise: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(settled[IDX_BOOSTUVP]) |-> flags[IDX_BOOSTUVP])
    else $error("Boost stop on bus under-voltage did not set its flag.");

  // An expiry edge that meets a read of its own register must survive.
  chk_set_wins: assert property (
    @(posedge clk) disable iff (!arst_n)
    (sync2[IDX_TOPUP] && sync3[IDX_TOPUP] && !settled[IDX_TOPUP]
     && rdStrobe && rdAddr == OFS_TIMER_FLAGS) |=> flags[IDX_TOPUP])
    else $error("Read clear overrode a same-cycle timer event.");

endmodule

// >>> test/cff_host_model.sv
`timescale 1ns/1ps

module cff_host_model
(
  // Clock.
  input  wire logic       clk,
  // Read answer from the flag bank.
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  // Read request towards the flag bank.
  output logic            rdStrobe,
  output logic      [7:0] rdAddr
);

  // Idle bus: no request pending.
  initial
  begin
    rdStrobe = 1'h0;
    rdAddr   = 8'h00;
  end

  // One read: a single strobe cycle, then the answer one cycle later.
  // The released address is scrambled so a stale value cannot help.
  task automatic read(input logic [7:0] addr, output logic [7:0] data,
                      output logic valid);
    @(posedge clk);
    rdStrobe <= 1'h1;
    rdAddr   <= addr;
    @(posedge clk);
    rdStrobe <= 1'h0;
    rdAddr   <= ~addr;
    #1;
    valid = rdValid;
    data  = rdData;
  endtask

endmodule

// >>> test/test_charger_fault_event_flags.sv
`timescale 1ns/1ps

`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin nMismatch++; \
  $display("Error at %0t got %h exp %h", $time, a, e); end end

module test_charger_fault_event_flags;
  import cff_pkg::*;

  logic       clk;
  logic       arst_n;
  cff_cond_t  condIn;
  cff_cond_t  prevCond;
  cff_cond_t  nextCond;
  logic       rdStrobe;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  logic       rdValid;
  logic [7:0] got;
  logic       gotValid;
  int         nMismatch;
  int         checkCount;

  cff_flag_bank cff_flag_bank_i (.clk(clk), .arst_n(arst_n),
    .condIn(condIn), .rdStrobe(rdStrobe), .rdAddr(rdAddr),
    .rdData(rdData), .rdValid(rdValid));

  cff_host_model cff_host_model_i (.clk(clk), .rdData(rdData),
    .rdValid(rdValid), .rdStrobe(rdStrobe), .rdAddr(rdAddr));

  // Free-running core clock of 8 ns.
  initial clk = 1'h0;
  always #4 clk = ~clk;

  // Expected flag bytes {27h, 26h, 25h, 24h} from rising and falling levels.
  function automatic logic [31:0] expect_flags(cff_cond_t r, cff_cond_t f);
    logic [18:0] ev;
    ev = r | (f & CHANGE_MODE);
    return {ev[4:1], 1'h0, ev[0], 2'h0, ev[12:5], 3'h0, ev[17:13],
            7'h00, ev[18]};
  endfunction

  // One read through the host and a comparison of its answer.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    cff_host_model_i.read(a, got, gotValid);
    `CHK(gotValid, 1'h1)
    `CHK(got, e)
  endtask

  // Reads all four flag registers in turn.
  task automatic read_all(input logic [31:0] e);
    rc(OFS_TIMER_FLAGS, e[7:0]);
    rc(OFS_TEMP_FLAGS, e[15:8]);
    rc(OFS_FAULT_A, e[23:16]);
    rc(OFS_FAULT_B, e[31:24]);
  endtask

  // Leaves time for a condition to pass the synchroniser.
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    end_of_test();
  end

  // Main sequence.
  initial
  begin
    arst_n = 1'h0;
    condIn = '0;
    nMismatch = 0;
    checkCount = 0;
    void'($urandom(13));
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    read_all(32'h0);
    // Each condition alone: raise, drop, read the latched flag, then read again to see it cleared.
    for (int i = 0; i < NUM_COND; i++)
    begin
      nextCond = cff_cond_t'(19'h1 << i);
      @(posedge clk);
      condIn <= nextCond;
      settle();
      condIn <= '0;
      settle();
      read_all(expect_flags(nextCond, nextCond));
      read_all(32'h0);
    end
    // An expiry edge landing on the read of its register outlives the clear.
    @(posedge clk);
    condIn <= cff_cond_t'(19'h1 << IDX_TOPUP);
    repeat (2) @(posedge clk);
    rc(OFS_TIMER_FLAGS, 8'h00);
    rc(OFS_TIMER_FLAGS, 8'h01);
    @(posedge clk);
    condIn <= '0;
    settle();
    // Random condition patterns, each followed by a full sweep.
    for (int n = 0; n < 24; n++)
    begin
      prevCond = condIn;
      nextCond = cff_cond_t'(19'($urandom));
      @(posedge clk);
      condIn <= nextCond;
      settle();
      read_all(expect_flags(nextCond & ~prevCond,
                            prevCond & ~nextCond));
      rc(8'h28 + 8'($urandom_range(200)), 8'h00);
    end
    // Reset in mid-run with flags pending clears everything.
    @(posedge clk);
    condIn <= '1;
    settle();
    arst_n <= 1'h0;
    condIn <= '0;
    @(posedge clk);
    arst_n <= 1'h1;
    read_all(32'h0);
    end_of_test();
  end

endmodule
